// ---- vgc_pkg.sv ----
// Purpose: Shared constants for the version, gain and calibration register bank.
// Assumes: APB with 32-bit data; each register sits in one aligned word.
// Notes: Register indices are kept; the byte address is four times the index.
package vgc_pkg;
   // =====================================================================
   // Register indices and byte addresses
   // =====================================================================
   localparam int unsigned VGC_ADDR_W = 8;
   localparam logic [VGC_ADDR_W-1:0] VGC_IDX_REVISION = 8'h08;
   localparam logic [VGC_ADDR_W-1:0] VGC_IDX_RESERVED = 8'h09;
   localparam logic [VGC_ADDR_W-1:0] VGC_IDX_GAIN = 8'h0A;
   localparam logic [VGC_ADDR_W-1:0] VGC_IDX_SLOPE = 8'h0B;
   localparam logic [VGC_ADDR_W-1:0] VGC_IDX_OFFSET = 8'h0C;
   localparam logic [VGC_ADDR_W-1:0] VGC_IDX_SETUP = 8'h10;
   localparam int unsigned VGC_WORD_SHIFT = 2;

   // =====================================================================
   // Field layouts and reset values
   // =====================================================================
   localparam int unsigned VGC_VER_W = 4;
   localparam int unsigned VGC_VER_LSB = 4;
   localparam int unsigned VGC_GAIN_W = 5;
   localparam int unsigned VGC_GAIN_LSB = 0;
   localparam int unsigned VGC_SLOPE_W = 5;
   localparam int unsigned VGC_SLOPE_LSB = 3;
   localparam int unsigned VGC_OFFSET_W = 6;
   localparam int unsigned VGC_OFFSET_LSB = 0;
   localparam int unsigned VGC_SETUP_PATH_BIT = 0;
   localparam logic [VGC_GAIN_W-1:0] VGC_GAIN_RESET = 5'h1A;
   localparam logic [VGC_GAIN_W-1:0] VGC_GAIN_UNITY = 5'h1A;
   localparam logic [7:0] VGC_RESERVED_RESET = 8'h00;
   localparam logic VGC_SETUP_PATH_RESET = 1'b1;
   localparam int unsigned VGC_SYNC_W = VGC_SLOPE_W + VGC_OFFSET_W + 1;
endpackage

// ---- vgc_regs.sv ----
// Purpose: Version, buffer gain and temperature calibration registers on APB.
// Assumes: Fuse values arrive as levels with a valid flag from outside the domain.
// Notes: Every access completes with one wait state.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module vgc_regs #(
   parameter logic [vgc_pkg::VGC_VER_W-1:0] VERSION = 4'h2 // Arbitrary value.
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [vgc_pkg::VGC_ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [vgc_pkg::VGC_SLOPE_W-1:0] otp_slope_i,
   input wire logic [vgc_pkg::VGC_OFFSET_W-1:0] otp_offset_i,
   input wire logic otp_valid_i,
   output logic [vgc_pkg::VGC_GAIN_W-1:0] buf_gain_o,
   output logic buf_in_path_o
);
   import vgc_pkg::*;

   initial begin
      if (VERSION == '0) begin
         $error("VERSION must not be zero");
      end
   end

   logic [VGC_GAIN_W-1:0] gain_code;
   logic [7:0] reserved_reg;
   logic path_sel;
   logic [VGC_SLOPE_W-1:0] slope_code;
   logic [VGC_OFFSET_W-1:0] offset_code;
   logic xfer_done;
   logic wr_done;
   logic [VGC_ADDR_W-1:0] reg_idx;
   logic aligned;
   logic hit;
   logic [31:0] next_rdata;
   logic otp_valid_s;
   logic otp_valid_q;
   logic [VGC_SLOPE_W-1:0] otp_slope_s;
   logic [VGC_OFFSET_W-1:0] otp_offset_s;

   // =====================================================================
   // Fuse input synchronisation
   // =====================================================================
   vgc_sync_if #(.WIDTH(VGC_SYNC_W)) otp_if ();

   // The whole fuse group is sampled together and used only once valid settles.
   assign otp_if.raw = {otp_valid_i, otp_offset_i, otp_slope_i};
   assign {otp_valid_s, otp_offset_s, otp_slope_s} = otp_if.synced;

   vgc_sync #(.WIDTH(VGC_SYNC_W)) u_otp_sync (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .port(otp_if)
   );

   // Codes and valid cross in one group, so a code bit that moves with valid may be
   // caught half-settled; one more edge gives a fresh, settled sample before loading.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         otp_valid_q <= 1'b0;
      end else begin
         otp_valid_q <= otp_valid_s;
      end
   end

   // Fuse codes load once valid has stood for two edges; before that they read zero.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         slope_code <= '0;
         offset_code <= '0;
      end else if (otp_valid_s && otp_valid_q) begin
         slope_code <= otp_slope_s;
         offset_code <= otp_offset_s;
      end
   end

   // =====================================================================
   // APB decode
   // =====================================================================
   // Byte address is the index shifted by one word; misaligned is unmapped.
   assign reg_idx = paddr_i >> VGC_WORD_SHIFT;
   assign aligned = (paddr_i[VGC_WORD_SHIFT-1:0] == '0);
   assign hit = aligned && (reg_idx == VGC_IDX_REVISION || reg_idx == VGC_IDX_RESERVED ||
                reg_idx == VGC_IDX_GAIN || reg_idx == VGC_IDX_SLOPE ||
                reg_idx == VGC_IDX_OFFSET || reg_idx == VGC_IDX_SETUP);
   assign xfer_done = psel_i && penable_i && pready_o;
   assign wr_done = xfer_done && pwrite_i && hit;

   // Read mux; unused bits stay zero so narrow fields read clean.
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (aligned) begin
         case (reg_idx)
            VGC_IDX_REVISION: next_rdata[VGC_VER_LSB +: VGC_VER_W] = VERSION;
            VGC_IDX_RESERVED: next_rdata[7:0] = reserved_reg;
            VGC_IDX_GAIN: next_rdata[VGC_GAIN_LSB +: VGC_GAIN_W] = gain_code;
            VGC_IDX_SLOPE: next_rdata[VGC_SLOPE_LSB +: VGC_SLOPE_W] = slope_code;
            VGC_IDX_OFFSET: next_rdata[VGC_OFFSET_LSB +: VGC_OFFSET_W] = offset_code;
            VGC_IDX_SETUP: next_rdata[VGC_SETUP_PATH_BIT] = path_sel;
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // One wait state: ready rises in the second access cycle, data with it.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         pready_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= psel_i && penable_i && !pready_o;
         if (psel_i && penable_i && !pready_o) begin
            prdata_o <= pwrite_i ? 32'h0000_0000 : next_rdata;
            pslverr_o <= !hit;
         end else begin
            pslverr_o <= 1'b0;
         end
      end
   end

   // =====================================================================
   // Writable registers
   // =====================================================================
   // Only the gain field, reserved word and path bit take writes.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         gain_code <= VGC_GAIN_RESET;
         reserved_reg <= VGC_RESERVED_RESET;
         path_sel <= VGC_SETUP_PATH_RESET;
      end else if (wr_done) begin
         if (reg_idx == VGC_IDX_GAIN) begin
            gain_code <= pwdata_i[VGC_GAIN_LSB +: VGC_GAIN_W];
         end
         if (reg_idx == VGC_IDX_RESERVED) begin
            reserved_reg <= pwdata_i[7:0];
         end
         if (reg_idx == VGC_IDX_SETUP) begin
            path_sel <= pwdata_i[VGC_SETUP_PATH_BIT];
         end
      end
   end

   // =====================================================================
   // Analog buffer control
   // =====================================================================
   // Bypassed buffer sees unity so the analog side never runs a stale gain.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         buf_gain_o <= VGC_GAIN_UNITY;
         buf_in_path_o <= 1'b0;
      end else begin
         buf_in_path_o <= path_sel;
         buf_gain_o <= path_sel ? gain_code : VGC_GAIN_UNITY;
      end
   end

   // =====================================================================
   // Assertions
   // =====================================================================
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   a_version_read: assert property (xfer_done && !pwrite_i && aligned &&
      reg_idx == VGC_IDX_REVISION |-> prdata_o == {24'h0, VERSION, 4'h0})
      else $error("version read wrong");
   a_gain_upper_zero: assert property (xfer_done && !pwrite_i && aligned &&
      reg_idx == VGC_IDX_GAIN |-> prdata_o[31:VGC_GAIN_W] == '0)
      else $error("gain upper bits not zero");
   a_gain_write_takes: assert property (wr_done && reg_idx == VGC_IDX_GAIN
      |=> gain_code == $past(pwdata_i[VGC_GAIN_W-1:0]))
      else $error("gain write lost");
   a_gain_read_back: assert property (xfer_done && !pwrite_i && aligned &&
      reg_idx == VGC_IDX_GAIN |-> prdata_o == {27'h0, $past(gain_code)})
      else $error("gain read wrong");
   a_slope_low_zero: assert property (xfer_done && !pwrite_i && aligned &&
      reg_idx == VGC_IDX_SLOPE |-> prdata_o[VGC_SLOPE_LSB-1:0] == '0)
      else $error("slope low bits not zero");
   a_slope_read_back: assert property (xfer_done && !pwrite_i && aligned &&
      reg_idx == VGC_IDX_SLOPE |-> prdata_o == {24'h0, $past(slope_code), 3'h0})
      else $error("slope read wrong");
   a_offset_read_back: assert property (xfer_done && !pwrite_i && aligned &&
      reg_idx == VGC_IDX_OFFSET |-> prdata_o == {26'h0, $past(offset_code)})
      else $error("offset read wrong");
   a_reserved_read_back: assert property (xfer_done && !pwrite_i && aligned &&
      reg_idx == VGC_IDX_RESERVED |-> prdata_o == {24'h0, $past(reserved_reg)})
      else $error("reserved read wrong");
   a_slope_write_ignored: assert property (xfer_done && pwrite_i &&
      reg_idx == VGC_IDX_SLOPE && !otp_valid_s |=> $stable(slope_code))
      else $error("slope changed by write");
   a_fuse_held: assert property (!otp_valid_s |=> $stable(slope_code) &&
      $stable(offset_code))
      else $error("fuse code moved without valid");
   a_reserved_isolated: assert property (wr_done && reg_idx == VGC_IDX_RESERVED
      |=> $stable(gain_code) ##1 $stable(buf_gain_o))
      else $error("reserved write disturbed gain");
   a_gain_applied: assert property (path_sel ##1 path_sel
      |-> buf_in_path_o && buf_gain_o == $past(gain_code))
      else $error("gain not applied in path");
   a_bypass_unity: assert property (!path_sel |=> buf_gain_o == VGC_GAIN_UNITY)
      else $error("bypass gain not unity");
   a_path_follows: assert property (1'b1 |=> buf_in_path_o == $past(path_sel))
      else $error("path output stale");
   a_read_no_effect: assert property (xfer_done && !pwrite_i
      |=> $stable(gain_code) && $stable(reserved_reg) && !pready_o)
      else $error("read had a side effect");
endmodule

// ---- vgc_regs_tb_top.sv ----
// Purpose: Self-checking bench for the version, gain and calibration register bank.
// Assumes: APB answers with a wait state; the bench waits for pready_o under a bound.
// Notes: Byte address is the register index shifted by the word shift.
`timescale 1ns/1ps
module vgc_regs_tb_top;
   import vgc_pkg::*;
   // =====================================================================
   // Clock, reset and design instance
   // =====================================================================
   localparam logic [VGC_VER_W-1:0] TB_VERSION = 4'h5; // Arbitrary value.
   localparam int TB_SLOPE_BASE = 32'h33; // Slope magnitude of code zero, 51 LSB per kelvin.
   logic [31:0] rd_w;
   logic er_w;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [VGC_ADDR_W-1:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [VGC_SLOPE_W-1:0] otp_slope = 5'h00;
   logic [VGC_OFFSET_W-1:0] otp_offset = 6'h00;
   logic otp_valid = 1'b0;
   logic [VGC_GAIN_W-1:0] buf_gain;
   logic buf_in_path;
   int n_errors = 0;
   int checks = 0;
   logic [7:0] gain_codes [5] = '{8'h01, 8'h03, 8'h0A, 8'h11, 8'h1A};

   // The clock toggles every half period of 25 ns.
   always #25 clk_sys_i = ~clk_sys_i;

   vgc_regs #(.VERSION(TB_VERSION)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .otp_slope_i(otp_slope), .otp_offset_i(otp_offset), .otp_valid_i(otp_valid),
      .buf_gain_o(buf_gain), .buf_in_path_o(buf_in_path));

   // =====================================================================
   // Shared tasks
   // =====================================================================
   // Compares one seen value with its expectation and counts the result.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then stops the run.
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // One APB transfer, entered just after a rising edge; it returns one edge after release.
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= idx << VGC_WORD_SHIFT;
      pwdata <= wd;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      // Values read right after the edge are those sampled at that edge.
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      if (n >= 20) begin
         n_errors++;
         $display("MISMATCH at %0t: no ready within bound", $time);
         tally_and_finish();
      end else begin
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clk_sys_i);
      end
   endtask

   // Writes a word and expects no error.
   task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
      logic [31:0] rd;
      logic er;
      apb(1'b1, idx, wd, rd, er);
      chk({31'h0, er}, 32'h0, "write error flag");
   endtask

   // Reads a word and compares data and error flag.
   task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input logic experr);
      logic [31:0] rd;
      logic er;
      apb(1'b0, idx, 32'h0, rd, er);
      chk(rd, exp, "read data");
      chk({31'h0, er}, {31'h0, experr}, "read error flag");
   endtask

   // Looks at the analog outputs mid-cycle, one edge after a write landed.
   task automatic outs(input logic [4:0] g, input logic p);
      @(negedge clk_sys_i);
      chk({27'h0, buf_gain}, {27'h0, g}, "gain output");
      chk({31'h0, buf_in_path}, {31'h0, p}, "path output");
      @(posedge clk_sys_i);
   endtask

   // =====================================================================
   // Main sequence
   // =====================================================================
   initial begin
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      rdc(VGC_IDX_REVISION, {24'h0, TB_VERSION, 4'h0}, 1'b0);
      wr(VGC_IDX_REVISION, 32'hFF);
      rdc(VGC_IDX_REVISION, {24'h0, TB_VERSION, 4'h0}, 1'b0);
      rdc(VGC_IDX_GAIN, {27'h0, VGC_GAIN_RESET}, 1'b0);
      outs(VGC_GAIN_RESET, 1'b1);
      $display("test version and reset done");
      wr(VGC_IDX_GAIN, 32'hFFFF_FFE4);
      rdc(VGC_IDX_GAIN, 32'h04, 1'b0);
      for (int i = 0; i < 5; i++) begin
         wr(VGC_IDX_GAIN, {24'h0, gain_codes[i]});
         rdc(VGC_IDX_GAIN, {24'h0, gain_codes[i]}, 1'b0);
         outs(gain_codes[i][4:0], 1'b1);
      end
      wr(VGC_IDX_GAIN, 32'h11);
      wr(VGC_IDX_SETUP, 32'h0);
      outs(VGC_GAIN_UNITY, 1'b0);
      rdc(VGC_IDX_GAIN, 32'h11, 1'b0);
      wr(VGC_IDX_SETUP, 32'h1);
      outs(5'h11, 1'b1);
      $display("test gain codes and path done");
      wr(VGC_IDX_RESERVED, 32'h5A);
      rdc(VGC_IDX_RESERVED, 32'h5A, 1'b0);
      rdc(8'h14, 32'h0, 1'b1);
      $display("test reserved and unmapped done");
      // A write before the fuses load must not reach the read-only slope code.
      wr(VGC_IDX_SLOPE, 32'hFF);
      rdc(VGC_IDX_SLOPE, 32'h0, 1'b0);
      otp_slope <= 5'h13;
      otp_offset <= 6'h2D;
      otp_valid <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      rdc(VGC_IDX_SLOPE, {24'h0, 5'h13, 3'h0}, 1'b0);
      rdc(VGC_IDX_OFFSET, {26'h0, 6'h2D}, 1'b0);
      // The host turns the read code into a slope; code 19 must give -70 LSB per kelvin.
      apb(1'b0, VGC_IDX_SLOPE, 32'h0, rd_w, er_w);
      chk(-(TB_SLOPE_BASE + int'(rd_w[VGC_SLOPE_LSB +: VGC_SLOPE_W])), 32'hFFFF_FFBA,
          "slope per kelvin");
      chk({31'h0, er_w}, 32'h0, "slope error flag");
      wr(VGC_IDX_SLOPE, 32'hFF);
      wr(VGC_IDX_OFFSET, 32'h00);
      rdc(VGC_IDX_SLOPE, 32'h98, 1'b0);
      rdc(VGC_IDX_OFFSET, 32'h2D, 1'b0);
      $display("test calibration codes done");
      // The host leaves the buffer gain at its default once testing is over.
      wr(VGC_IDX_GAIN, {27'h0, VGC_GAIN_RESET});
      rdc(VGC_IDX_GAIN, {27'h0, VGC_GAIN_RESET}, 1'b0);
      $display("test gain restore done");
      tally_and_finish();
   end
endmodule

// ---- vgc_sync.sv ----
// Purpose: Two-flop synchroniser for a group of slow level signals.
// Assumes: The inputs change rarely and settle before they are used.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module vgc_sync #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   vgc_sync_if.sync port
);
   logic [WIDTH-1:0] stage1;

   // =====================================================================
   // Synchroniser
   // =====================================================================
   // Two stages bound the metastability window before any logic looks.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         stage1 <= '0;
         port.synced <= '0;
      end else begin
         stage1 <= port.raw;
         port.synced <= stage1;
      end
   end
endmodule

// ---- vgc_sync_if.sv ----
// Purpose: Carries the raw and synchronised fuse-memory signals.
// Assumes: One clock domain on the synchronised side.
// Notes: The raw side comes from outside the clock domain.
`timescale 1ns/1ps
interface vgc_sync_if #(parameter int unsigned WIDTH = 1);
   logic [WIDTH-1:0] raw;
   logic [WIDTH-1:0] synced;
   modport sync (input raw, output synced);
   modport user (output raw, input synced);
endinterface
